// file: shared/macfg_pkg.sv
// package for the monitor converter and zero-crossing configuration bank
package macfg_pkg;

  // register offsets
  localparam logic [7:0] MACFG_IMON_AVG_ADDR = 8'h31;
  localparam logic [7:0] MACFG_OUTPUT_SENSE_VOLTAGE_AVG_ADDR = 8'h32;
  localparam logic [7:0] MACFG_TSEN_AVG_ADDR = 8'h33;
  localparam logic [7:0] MACFG_ZCD_ADDR = 8'h34;
  localparam logic [7:0] MACFG_PHASE_ADDR = 8'h36;
  localparam logic [7:0] MACFG_VENDOR_ADDR = 8'h37;
  localparam logic [7:0] MACFG_DEVICE_ADDR = 8'h38;
  localparam logic [7:0] MACFG_STRAP_V1_ADDR = 8'h40;
  localparam logic [7:0] MACFG_STRAP_I1_ADDR = 8'h41;

  // field positions inside the zero-crossing register
  localparam int MACFG_ZCD_DIS_BIT = 5;
  localparam int MACFG_ZCD_DIR_BIT = 4;
  localparam int MACFG_ZCD_MAG_MSB = 3;

  // reset values
  localparam logic [1:0] MACFG_AVG_RESET = 2'h0;
  localparam logic [5:0] MACFG_ZCD_RESET = 6'h00;
  localparam logic [3:0] MACFG_STRAP_RESET = 4'h0;
  localparam logic [2:0] MACFG_PHASE_RESET = 3'h0;

  // averaging codes
  localparam logic [1:0] MACFG_AVG_8 = 2'h0;
  localparam logic [1:0] MACFG_AVG_4 = 2'h1;
  localparam logic [1:0] MACFG_AVG_2 = 2'h2;
  localparam logic [1:0] MACFG_AVG_16 = 2'h3;

  // timing: clock rate and eight-sample windows in microseconds
  localparam int MACFG_CLK_MHZ = 40;
  localparam int MACFG_IMON_WIN8_US = 112;
  localparam int MACFG_SENSE_WIN8_US = 336;
  localparam int MACFG_WIN_SAMPLES = 8;
  localparam int MACFG_IMON_SAMPLE_CYC = MACFG_IMON_WIN8_US * MACFG_CLK_MHZ / MACFG_WIN_SAMPLES;
  localparam int MACFG_SENSE_SAMPLE_CYC =
    MACFG_SENSE_WIN8_US * MACFG_CLK_MHZ / MACFG_WIN_SAMPLES;

  // threshold step of the zero-crossing offset, in microvolts
  localparam int MACFG_ZCD_STEP_UV = 310;

  // channel count: current monitor, output sense, temperature sense
  localparam int MACFG_NCH = 3;

  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } macfg_req_s;

  // zero-crossing offset setting
  typedef struct packed {
    logic disable_off;
    logic decrease;
    logic [3:0] magnitude;
  } macfg_zcd_s;

  // averaging engine state
  typedef enum logic [1:0] {
    MACFG_AVG_RUN = 2'b01,
    MACFG_AVG_RESTART = 2'b10
  } macfg_avg_e;

endpackage

// file: logic/macfg_bank.sv
// register bank with converter averaging and zero-crossing offset setting
`timescale 1ns/1ps
module macfg_bank
  import macfg_pkg::*;
#(
  parameter logic [7:0] VENDOR_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'ha5, // arbitrary value
  parameter int SAMPLE_W = 8
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // register access port
  input wire macfg_req_s req_in,
  output logic [7:0] reg_rdata_out,
  // converter samples, index 0 current, 1 output sense, 2 temperature
  output logic [MACFG_NCH-1:0] conv_req_out,
  input wire logic [MACFG_NCH-1:0] sample_valid_in,
  input wire logic [MACFG_NCH-1:0][SAMPLE_W-1:0] sample_data_in,
  // averaged results
  output logic [MACFG_NCH-1:0][SAMPLE_W-1:0] avg_result_out,
  output logic [MACFG_NCH-1:0] result_update_out,
  // phase status from the power stage
  input wire logic [2:0] phase_code_in,
  // settings to the analog side
  output logic zcd_offset_apply_out,
  output logic signed [4:0] zcd_offset_steps_out,
  output logic [3:0] strap_voltage_setting_one_out,
  output logic [3:0] strap_current_setting_one_out
);

  localparam int ACC_W = SAMPLE_W + 4;

  // number of samples for an averaging code
  function automatic logic [4:0] avg_samples(input logic [1:0] code);
    case (code)
      MACFG_AVG_8: avg_samples = 5'd8;
      MACFG_AVG_4: avg_samples = 5'd4;
      MACFG_AVG_2: avg_samples = 5'd2;
      default: avg_samples = 5'd16;
    endcase
  endfunction

  // right shift that divides by the sample count
  function automatic logic [2:0] avg_shift(input logic [1:0] code);
    case (code)
      MACFG_AVG_8: avg_shift = 3'd3;
      MACFG_AVG_4: avg_shift = 3'd2;
      MACFG_AVG_2: avg_shift = 3'd1;
      default: avg_shift = 3'd4;
    endcase
  endfunction

  // sample spacing per channel
  function automatic logic [10:0] sample_gap(input int ch);
    if (ch == 0) begin
      sample_gap = 11'(MACFG_IMON_SAMPLE_CYC - 1);
    end else begin
      sample_gap = 11'(MACFG_SENSE_SAMPLE_CYC - 1);
    end
  endfunction

  // configuration registers
  logic [MACFG_NCH-1:0][1:0] avg_code_r, avg_code_nxt;
  macfg_zcd_s zcd_r, zcd_nxt;
  logic [3:0] strap_v_r, strap_v_nxt;
  logic [3:0] strap_i_r, strap_i_nxt;
  logic [2:0] phase_r, phase_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [MACFG_NCH-1:0] code_written;

  // register writes and phase capture
  always_comb begin
    avg_code_nxt = avg_code_r;
    zcd_nxt = zcd_r;
    strap_v_nxt = strap_v_r;
    strap_i_nxt = strap_i_r;
    code_written = '0;
    phase_nxt = phase_code_in;
    if (req_in.wr) begin
      case (req_in.addr)
        MACFG_IMON_AVG_ADDR: begin
          avg_code_nxt[0] = req_in.wdata[1:0];
          code_written[0] = 1'b1;
        end
        MACFG_OUTPUT_SENSE_VOLTAGE_AVG_ADDR: begin
          avg_code_nxt[1] = req_in.wdata[1:0];
          code_written[1] = 1'b1;
        end
        MACFG_TSEN_AVG_ADDR: begin
          avg_code_nxt[2] = req_in.wdata[1:0];
          code_written[2] = 1'b1;
        end
        MACFG_ZCD_ADDR: begin
          zcd_nxt.disable_off = req_in.wdata[MACFG_ZCD_DIS_BIT];
          zcd_nxt.decrease = req_in.wdata[MACFG_ZCD_DIR_BIT];
          zcd_nxt.magnitude = req_in.wdata[MACFG_ZCD_MAG_MSB:0];
        end
        MACFG_STRAP_V1_ADDR: strap_v_nxt = req_in.wdata[3:0];
        MACFG_STRAP_I1_ADDR: strap_i_nxt = req_in.wdata[3:0];
        default: ;
      endcase
    end
  end

  // read data, unmapped offsets read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (req_in.rd) begin
      case (req_in.addr)
        MACFG_IMON_AVG_ADDR: rdata_nxt = {6'h00, avg_code_r[0]};
        MACFG_OUTPUT_SENSE_VOLTAGE_AVG_ADDR: rdata_nxt = {6'h00, avg_code_r[1]};
        MACFG_TSEN_AVG_ADDR: rdata_nxt = {6'h00, avg_code_r[2]};
        MACFG_ZCD_ADDR: rdata_nxt = {2'h0, zcd_r};
        MACFG_PHASE_ADDR: rdata_nxt = {5'h00, phase_r};
        MACFG_VENDOR_ADDR: rdata_nxt = VENDOR_CODE;
        MACFG_DEVICE_ADDR: rdata_nxt = DEVICE_CODE;
        MACFG_STRAP_V1_ADDR: rdata_nxt = {4'h0, strap_v_r};
        MACFG_STRAP_I1_ADDR: rdata_nxt = {4'h0, strap_i_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // register stage for the configuration group
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      avg_code_r <= {MACFG_NCH{MACFG_AVG_RESET}};
      zcd_r <= MACFG_ZCD_RESET;
      strap_v_r <= MACFG_STRAP_RESET;
      strap_i_r <= MACFG_STRAP_RESET;
      phase_r <= MACFG_PHASE_RESET;
      rdata_r <= 8'h00;
    end else begin
      avg_code_r <= avg_code_nxt;
      zcd_r <= zcd_nxt;
      strap_v_r <= strap_v_nxt;
      strap_i_r <= strap_i_nxt;
      phase_r <= phase_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // zero-crossing offset as signed steps of the threshold unit
  logic signed [4:0] zcd_steps_r, zcd_steps_nxt;
  logic zcd_apply_r, zcd_apply_nxt;

  always_comb begin
    zcd_apply_nxt = !zcd_r.disable_off;
    if (!zcd_apply_nxt) begin
      zcd_steps_nxt = 5'sd0;
    end else if (zcd_r.decrease) begin
      zcd_steps_nxt = -$signed({1'b0, zcd_r.magnitude});
    end else begin
      zcd_steps_nxt = $signed({1'b0, zcd_r.magnitude});
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      zcd_apply_r <= 1'b1;
      zcd_steps_r <= 5'sd0;
    end else begin
      zcd_apply_r <= zcd_apply_nxt;
      zcd_steps_r <= zcd_steps_nxt;
    end
  end

  // averaging engines and conversion pacing
  macfg_avg_e st_r[MACFG_NCH], st_nxt[MACFG_NCH];
  logic [MACFG_NCH-1:0][ACC_W-1:0] acc_r, acc_nxt;
  logic [MACFG_NCH-1:0][4:0] cnt_r, cnt_nxt;
  logic [MACFG_NCH-1:0][SAMPLE_W-1:0] res_r, res_nxt;
  logic [MACFG_NCH-1:0] upd_r, upd_nxt;
  logic [MACFG_NCH-1:0][10:0] gap_r, gap_nxt;
  logic [MACFG_NCH-1:0] req_r, req_nxt;

  always_comb begin
    logic [ACC_W-1:0] sum;
    sum = '0;
    for (int ch = 0; ch < MACFG_NCH; ch++) begin
      st_nxt[ch] = st_r[ch];
      acc_nxt[ch] = acc_r[ch];
      cnt_nxt[ch] = cnt_r[ch];
      res_nxt[ch] = res_r[ch];
      upd_nxt[ch] = 1'b0;
      // one conversion request per sample slot
      req_nxt[ch] = (gap_r[ch] == 11'd0);
      gap_nxt[ch] = (gap_r[ch] == 11'd0) ? sample_gap(ch) : gap_r[ch] - 11'd1;
      sum = acc_r[ch] + ACC_W'(sample_data_in[ch]);
      case (st_r[ch])
        MACFG_AVG_RESTART: begin
          // drop the partial sum of the old setting
          acc_nxt[ch] = '0;
          cnt_nxt[ch] = 5'd0;
          st_nxt[ch] = MACFG_AVG_RUN;
        end
        MACFG_AVG_RUN: begin
          if (sample_valid_in[ch]) begin
            if (cnt_r[ch] + 5'd1 == avg_samples(avg_code_r[ch])) begin
              res_nxt[ch] = SAMPLE_W'(sum >> avg_shift(avg_code_r[ch]));
              upd_nxt[ch] = 1'b1;
              acc_nxt[ch] = '0;
              cnt_nxt[ch] = 5'd0;
            end else begin
              acc_nxt[ch] = sum;
              cnt_nxt[ch] = cnt_r[ch] + 5'd1;
            end
          end
        end
        default: st_nxt[ch] = MACFG_AVG_RESTART;
      endcase
      if (code_written[ch]) begin
        st_nxt[ch] = MACFG_AVG_RESTART;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      for (int ch = 0; ch < MACFG_NCH; ch++) begin
        st_r[ch] <= MACFG_AVG_RESTART;
      end
      acc_r <= '0;
      cnt_r <= '0;
      res_r <= '0;
      upd_r <= '0;
      gap_r <= '0;
      req_r <= '0;
    end else begin
      st_r <= st_nxt;
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      res_r <= res_nxt;
      upd_r <= upd_nxt;
      gap_r <= gap_nxt;
      req_r <= req_nxt;
    end
  end

  // outputs
  assign reg_rdata_out = rdata_r;
  assign conv_req_out = req_r;
  assign avg_result_out = res_r;
  assign result_update_out = upd_r;
  assign zcd_offset_apply_out = zcd_apply_r;
  assign zcd_offset_steps_out = zcd_steps_r;
  assign strap_voltage_setting_one_out = strap_v_r;
  assign strap_current_setting_one_out = strap_i_r;

  // checking helpers: samples taken since the last result per channel
  logic [MACFG_NCH-1:0][4:0] seen_r;
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      seen_r <= '0;
    end else begin
      for (int ch = 0; ch < MACFG_NCH; ch++) begin
        if (code_written[ch]) begin
          seen_r[ch] <= 5'd0;
        end else if (upd_r[ch]) begin
          // a sample in the result cycle already opens the next average
          seen_r[ch] <= {4'h0, sample_valid_in[ch] && st_r[ch] == MACFG_AVG_RUN};
        end else if (sample_valid_in[ch] && st_r[ch] == MACFG_AVG_RUN) begin
          seen_r[ch] <= seen_r[ch] + 5'd1;
        end
      end
    end
  end

  sequence s_zcd_write;
    req_in.wr && req_in.addr == MACFG_ZCD_ADDR;
  endsequence

  sequence s_phase_read;
    req_in.rd && !req_in.wr && req_in.addr == MACFG_PHASE_ADDR;
  endsequence

  AST_IMON_AVG_N: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    result_update_out[0] && !$past(code_written[0]) |-> seen_r[0] == avg_samples(avg_code_r[0]))
    else $error("current channel result after wrong sample count");

  AST_OUTPUT_SENSE_VOLTAGE_AVG_N: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    result_update_out[1] && !$past(code_written[1]) |-> seen_r[1] == avg_samples(avg_code_r[1]))
    else $error("output sense result after wrong sample count");

  AST_TSEN_AVG_N: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    result_update_out[2] && !$past(code_written[2]) |-> seen_r[2] == avg_samples(avg_code_r[2]))
    else $error("temperature result after wrong sample count");

  AST_ZCD_REMOVE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    s_zcd_write ##0 req_in.wdata[MACFG_ZCD_DIS_BIT] |-> ##2 !zcd_offset_apply_out &&
      zcd_offset_steps_out == 5'sd0)
    else $error("offset still applied after disable");

  AST_ZCD_DIRECTION: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    s_zcd_write ##0 !req_in.wdata[MACFG_ZCD_DIS_BIT] && req_in.wdata[MACFG_ZCD_DIR_BIT] |->
      ##2 zcd_offset_steps_out <= 5'sd0)
    else $error("decrease did not lower the threshold");

  AST_ZCD_MAGNITUDE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    s_zcd_write ##0 req_in.wdata[5:4] == 2'b00 |->
      ##2 zcd_offset_steps_out == $signed({1'b0, $past(req_in.wdata[3:0], 2)}))
    else $error("offset magnitude mismatch");

  AST_PHASE_READ: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    s_phase_read |=> reg_rdata_out == {5'h00, $past(phase_code_in, 2)})
    else $error("phase count read mismatch");

  AST_STRAP_V: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    req_in.wr && req_in.addr == MACFG_STRAP_V1_ADDR |=>
      strap_voltage_setting_one_out == $past(req_in.wdata[3:0]))
    else $error("voltage strap setting not stored");

  AST_RESULT_HOLD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !result_update_out[0] && !result_update_out[1] && !result_update_out[2] |->
      $stable(avg_result_out))
    else $error("result changed without a completed average");

endmodule

// file: testbench/macfg_conv_model.sv
// converter model answering conversion requests with paced sample pulses
`timescale 1ns/1ps
module macfg_conv_model
  import macfg_pkg::*;
(
  // clock
  input wire logic mclk_in,
  // requests from the bank and settings from the bench
  input wire logic [MACFG_NCH-1:0] conv_req_in,
  input wire logic [MACFG_NCH-1:0][7:0] base_in,
  input wire logic slow_in,
  // samples toward the bank and a sample count toward the bench
  output logic [MACFG_NCH-1:0] sample_valid_out,
  output logic [MACFG_NCH-1:0][7:0] sample_data_out,
  output logic [MACFG_NCH-1:0][15:0] sent_out
);
  logic [MACFG_NCH-1:0][3:0] wait_cnt = '0;
  logic [MACFG_NCH-1:0] odd = '0;

  // idle values at time zero
  initial begin
    sample_valid_out = '0;
    sample_data_out = '0;
    sent_out = '0;
  end

  // conversion delay, prompt or slow; data scrambled between samples
  always @(posedge mclk_in) begin
    #1;
    for (int ch = 0; ch < MACFG_NCH; ch++) begin
      if (wait_cnt[ch] == 4'h1) begin
        sample_valid_out[ch] = 1'b1;
        sample_data_out[ch] = base_in[ch] + {7'h0, odd[ch]}; // alternating lsb
        odd[ch] = ~odd[ch];
        sent_out[ch] = sent_out[ch] + 16'h1;
      end else begin
        sample_valid_out[ch] = 1'b0;
        sample_data_out[ch] = ~sample_data_out[ch];
      end
      if (conv_req_in[ch] === 1'b1) begin
        wait_cnt[ch] = slow_in ? 4'h9 : 4'h1;
      end else if (wait_cnt[ch] != 4'h0) begin
        wait_cnt[ch] = wait_cnt[ch] - 4'h1;
      end
    end
  end
endmodule

// file: testbench/macfg_bank_bench.sv
// self-checking bench for the averaging and zero-crossing register bank
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module macfg_bank_bench
  import macfg_pkg::*;
;
  localparam logic [7:0] BENCH_VENDOR = 8'h3c; // arbitrary value
  localparam logic [7:0] BENCH_DEVICE = 8'hc3; // arbitrary value
  localparam int NS [4] = '{8, 4, 2, 16};
  // expected cycles between conversion requests per channel
  localparam int PACE [MACFG_NCH] = '{MACFG_IMON_SAMPLE_CYC, MACFG_SENSE_SAMPLE_CYC,
    MACFG_SENSE_SAMPLE_CYC};
  // register rows: offset, write data, expected read back
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } macfg_row_s;
  macfg_row_s rows [11] = '{'{8'h31, 8'hff, 8'h03}, '{8'h32, 8'h02, 8'h02},
    '{8'h33, 8'h01, 8'h01}, '{8'h34, 8'h3f, 8'h3f}, '{8'h40, 8'ha5, 8'h05},
    '{8'h41, 8'hfc, 8'h0c}, '{8'h36, 8'hff, 8'h05}, '{8'h37, 8'h00, BENCH_VENDOR},
    '{8'h38, 8'h00, BENCH_DEVICE}, '{8'h35, 8'hff, 8'h00}, '{8'h50, 8'h77, 8'h00}};
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  macfg_req_s req = '0;
  logic [7:0] rdata;
  logic [MACFG_NCH-1:0] conv_req, valid, upd, upd_q;
  logic [MACFG_NCH-1:0][7:0] sdata, res, res_q;
  logic [MACFG_NCH-1:0][7:0] base = '0;
  logic [MACFG_NCH-1:0][15:0] sent;
  logic [2:0] phase_code = 3'h5;
  logic slow = 1'b0;
  logic apply;
  logic signed [4:0] steps, es;
  logic [3:0] strap_v, strap_i;
  logic [7:0] d;
  logic [5:0] v;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int t0, t1, t2, n0, n1, n2;
  int since_req [MACFG_NCH] = '{default: 0};

  macfg_bank #(.VENDOR_CODE(BENCH_VENDOR), .DEVICE_CODE(BENCH_DEVICE), .SAMPLE_W(8)) dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_in(req), .reg_rdata_out(rdata),
    .conv_req_out(conv_req), .sample_valid_in(valid), .sample_data_in(sdata),
    .avg_result_out(res), .result_update_out(upd), .phase_code_in(phase_code),
    .zcd_offset_apply_out(apply), .zcd_offset_steps_out(steps),
    .strap_voltage_setting_one_out(strap_v), .strap_current_setting_one_out(strap_i));

  macfg_conv_model conv (.mclk_in(mclk_in), .conv_req_in(conv_req), .base_in(base),
    .slow_in(slow), .sample_valid_out(valid), .sample_data_out(sdata), .sent_out(sent));

  // clock and cycle count
  always #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) cyc++;

  // results move only with a one-cycle update pulse; requests keep their spacing
  always @(posedge mclk_in) begin
    for (int ch = 0; ch < MACFG_NCH; ch++) begin
      if (reset_n_in && res[ch] !== res_q[ch]) `CHK("update_with_result", 1'b1, upd[ch])
      if (reset_n_in && upd_q[ch] === 1'b1) `CHK("update_pulse", 1'b0, upd[ch])
      if (!reset_n_in) begin
        since_req[ch] = 0;
      end else if (conv_req[ch] === 1'b1) begin
        if (since_req[ch] > 0) begin
          `CHK("req_pace", PACE[ch], since_req[ch])
        end
        since_req[ch] = 1;
      end else if (since_req[ch] > 0) begin
        since_req[ch]++;
      end
    end
    res_q <= res;
    upd_q <= upd;
  end

  task automatic end_of_test;
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] wd);
    @(posedge mclk_in);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
    @(posedge mclk_in);
    #1;
    req = '0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] rd);
    @(posedge mclk_in);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_in);
    #1;
    req = '0;
    rd = rdata;
  endtask

  // bounded wait for a result update, then check the average
  task automatic wait_upd(input int ch, output int t, output int n);
    bit hit;
    hit = 0;
    for (int k = 0; k < 40000 && !hit; k++) begin
      @(posedge mclk_in);
      #1;
      hit = (upd[ch] === 1'b1);
    end
    t = cyc;
    n = int'(sent[ch]);
    `CHK("update_seen", 1'b1, hit)
    `CHK("average", base[ch], res[ch])
  endtask

  // watchdog
  initial begin
    repeat (100000) @(posedge mclk_in);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge mclk_in);
    #1;
    reset_n_in = 1'b1;
    // ordinary register rows
    foreach (rows[i]) begin
      wr_reg(rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].addr, d);
      `CHK("reg_row", rows[i].exp, d)
    end
    `CHK("strap_v", 4'h5, strap_v)
    `CHK("strap_i", 4'hc, strap_i)
    // reset in mid-run returns defaults
    @(posedge mclk_in);
    #1;
    reset_n_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    reset_n_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_reg(rows[i].addr, d);
      `CHK("reset_value", 8'h00, d)
    end
    `CHK("reset_apply", 1'b1, apply)
    `CHK("reset_steps", 5'sh00, steps)
    `CHK("reset_strap", 8'h00, {strap_v, strap_i})
    // every zero-crossing setting
    for (int i = 0; i < 64; i++) begin
      v = i[5:0];
      es = v[5] ? 5'sh00 : (v[4] ? -$signed({1'b0, v[3:0]}) : $signed({1'b0, v[3:0]}));
      wr_reg(MACFG_ZCD_ADDR, {2'h0, v});
      @(posedge mclk_in);
      #1;
      `CHK("zcd_apply", ~v[5], apply)
      `CHK("zcd_steps", es, steps)
    end
    // phase count, one cycle old
    for (int i = 0; i < 8; i++) begin
      phase_code = i[2:0];
      rd_reg(MACFG_PHASE_ADDR, d);
      `CHK("phase", {5'h0, i[2:0]}, d)
    end
    // every averaging code on all channels, prompt converter for codes 0 and 2, slow converter for codes 1 and 3
    for (int c = 0; c < 4; c++) begin
      slow = c[0];
      for (int ch = 0; ch < MACFG_NCH; ch++) base[ch] = 8'(8'h10 * (c + 1) + ch);
      wr_reg(MACFG_IMON_AVG_ADDR, c[7:0]);
      wr_reg(MACFG_OUTPUT_SENSE_VOLTAGE_AVG_ADDR, c[7:0]);
      wr_reg(MACFG_TSEN_AVG_ADDR, c[7:0]);
      fork
        wait_upd(0, t0, n0);
        wait_upd(1, t1, n1);
        wait_upd(2, t2, n2);
      join
      wait_upd(0, t0, n0);
      wait_upd(0, t1, n1);
      `CHK("imon_window", NS[c] * MACFG_IMON_SAMPLE_CYC, t1 - t0)
      `CHK("imon_samples", NS[c], n1 - n0)
    end
    end_of_test();
  end
endmodule
